// *** shared/rtc_temp_comp_consts.vh ***
// register map, field positions, reset values and timing for temperature compensation
`ifndef RTC_TEMP_COMP_CONSTS_VH
`define RTC_TEMP_COMP_CONSTS_VH

// register byte addresses on the device register port
`define ALPHA_COLD_ADDR 8'h0C
`define SENSE_CTRL_ADDR 8'h0D
`define FINAL_AT_ADDR 8'h0E
`define FINAL_DT_ADDR 8'h0F

// fields of the sense control / step gain register
`define TSE_BIT 7
`define BATTERY_COMP_ENABLE_BIT 6
`define BATTERY_COMP_RATE_BIT 5
`define GAIN_MSB 4
`define GAIN_LSB 0

// reset values (first power-up)
`define ALPHA_RESET 8'h00
`define CTRL_RESET 8'h00
`define FINAL_AT_RESET 6'h00
`define FINAL_DT_RESET 5'h00
`define READ_ZERO 8'h00

// coefficient scale 2048 as a shift, plus half-degree temperature codes squared
`define ALPHA_SCALE_SHIFT 11
`define TEMP_SQ_SHIFT 2

// step gain: base of 16 sixteenths, raise flag at the gain msb
`define GAIN_UNITY 5'h10
`define GAIN_RAISE_BIT 4

// trim limits: analog magnitude 31, digital magnitude 10, digital step in analog steps
`define AT_MAX_MAG 6'h1F
`define DT_MAX_MAG 5'h0A
`define DT_STEP_IN_AT 6'h1F
`define AT_SIGN_BIT 5
`define DT_SIGN_BIT 4

// timing: conversion time in ms, clock in kHz, battery periods in minutes
`define CONV_TIME_MS 22
`define CLK_KHZ 50000
`define CONV_CYCLES (`CONV_TIME_MS * `CLK_KHZ)
`define PERIOD_LONG_MIN 10
`define PERIOD_SHORT_MIN 1
`define CYCLES_PER_MIN 36'hB2D05E00
`define PERIOD_LONG_CYCLES (`PERIOD_LONG_MIN * `CYCLES_PER_MIN)
`define PERIOD_SHORT_CYCLES (`PERIOD_SHORT_MIN * `CYCLES_PER_MIN)

// temperature code of the crystal turnover point
`define TURNOVER_CODE 10'h24E

`endif

// *** src/comp_period_timer.v ***
// periodic trigger for repeated temperature sense cycles
`timescale 1ns/100ps
`include "rtc_temp_comp_consts.vh"

module comp_period_timer #(
  parameter [35:0] LONG_CYCLES = `PERIOD_LONG_CYCLES,
  parameter [35:0] SHORT_CYCLES = `PERIOD_SHORT_CYCLES
) (
  input wire sys_clk,
  input wire reset,
  input wire run,
  input wire use_short,
  output reg tick
);

  reg [35:0] count_q; // cycles since the last trigger
  wire [35:0] limit; // selected period length

  assign limit = use_short ? SHORT_CYCLES : LONG_CYCLES;

  ////////////////////////////////////////////////////////////////////
  // counter restarts whenever the block is not allowed to run, so a
  // suppressed spell always costs one full period before the next cycle
  always @(posedge sys_clk) begin
    if (reset || !run) begin
      count_q <= 36'h000000000;
      tick <= 1'b0;
    end else if (count_q >= limit - 36'h000000001) begin
      count_q <= 36'h000000000;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 36'h000000001;
      tick <= 1'b0;
    end
  end

endmodule

// *** src/trim_calc.v ***
// temperature to final analog and digital trim arithmetic
`timescale 1ns/100ps
`include "rtc_temp_comp_consts.vh"

module trim_calc #(
  parameter [9:0] TURNOVER = `TURNOVER_CODE
) (
  input wire [9:0] temp_avg,
  input wire [7:0] alpha_cold,
  input wire [7:0] alpha_hot,
  input wire [4:0] gain,
  input wire [5:0] init_at,
  input wire [4:0] init_dt,
  output wire [5:0] final_at,
  output wire [4:0] final_dt
);

  wire below; // temperature on the cold side of turnover
  wire [9:0] mag; // distance from turnover in codes
  wire [7:0] alpha; // coefficient for this side
  wire [27:0] prod; // alpha times distance squared
  wire [9:0] ppm; // frequency shift to cancel, clipped
  wire [5:0] f16; // analog step size in sixteenths, 32 at the top gain
  wire [13:0] steps; // analog steps needed at this gain
  wire [13:0] dig_full; // whole digital steps before clipping
  wire [6:0] dig; // whole digital steps taken from the total
  wire [13:0] rem; // leftover analog steps
  wire [7:0] rem_sat; // leftover steps saturated to a byte
  wire [5:0] dt_enc; // digital trim encoding before narrowing
  wire signed [8:0] at_sum; // initial analog trim plus leftover
  wire signed [6:0] dt_sum; // initial digital trim plus whole steps

  assign below = temp_avg < TURNOVER;
  assign mag = below ? TURNOVER - temp_avg : temp_avg - TURNOVER;
  assign alpha = below ? alpha_cold : alpha_hot;
  assign prod = mag * mag * alpha;
  assign ppm = (prod[27:23] != 5'h00) ? 10'h3FF : prod[22:13];
  // gain codes 00001 to 01111 lower the step, codes with the msb set raise it
  // six bits so that the 2.0 code (32 sixteenths) cannot wrap to zero
  assign f16 = gain[`GAIN_RAISE_BIT] ? {1'b0, `GAIN_UNITY} + 6'h01 + {2'b00, gain[3:0]}
                                     : {1'b0, `GAIN_UNITY} - {2'b00, gain[3:0]};
  // a variable divide is large, but it runs once per conversion cycle
  assign steps = {ppm, 4'h0} / {8'h00, f16};
  assign dig_full = steps / {8'h00, `DT_STEP_IN_AT};
  assign dig = (dig_full > 14'h000A) ? 7'h0A : dig_full[6:0];
  assign rem = steps - {7'h00, dig} * {8'h00, `DT_STEP_IN_AT};
  // a clipped digital part leaves a large remainder; saturate, never wrap
  assign rem_sat = (rem[13:8] != 6'h00) ? 8'hFF : rem[7:0];
  assign at_sum = sm_at(init_at) + $signed({1'b0, rem_sat});
  assign dt_sum = sm_dt(init_dt) + $signed({1'b0, dig[5:0]});
  assign final_at = to_sm(at_sum, {3'h0, `AT_MAX_MAG}, `AT_SIGN_BIT);
  assign dt_enc = to_sm({{2{dt_sum[6]}}, dt_sum}, {4'h0, `DT_MAX_MAG}, `DT_SIGN_BIT);
  assign final_dt = dt_enc[4:0];

  // sign-magnitude analog trim to signed
  function signed [8:0] sm_at(input [5:0] v);
    sm_at = v[`AT_SIGN_BIT] ? -$signed({4'h0, v[4:0]}) : $signed({4'h0, v[4:0]});
  endfunction

  // sign-magnitude digital trim to signed
  function signed [6:0] sm_dt(input [4:0] v);
    sm_dt = v[`DT_SIGN_BIT] ? -$signed({3'h0, v[3:0]}) : $signed({3'h0, v[3:0]});
  endfunction

  // clip a signed value to +/- lim and encode as sign-magnitude
  function [5:0] to_sm(input signed [8:0] v, input [8:0] lim, input integer sb);
    reg [8:0] m;
    begin
      m = v[8] ? -v : v;
      if (m > lim) begin
        m = lim;
      end
      to_sm = m[5:0];
      if (v[8] && m != 9'h000) begin
        to_sm[sb] = 1'b1;
      end
    end
  endfunction

endmodule

// *** src/rtc_temp_compensation_ctrl.v ***
// temperature compensation control: coefficient, gain, sense enables, final trims
//
// Overview of operation
// - cold coefficient stores |alpha| times 2048
// - sense enable gates sensor, converter, trim; resets off
// - sensing off uses initial trims directly
// - enable starts two conversions, average stored
// - whole sequence ends about 22 ms after a write with sensing already allowed; an enabling write waits one repeat period
// - battery enable permits battery-mode compensation, default off
// - battery below 2.7 V suppresses battery-mode compensation
// - battery period 10 min or 1 min
// - battery conversion takes same 22 ms
// - 5-bit gain scales analog trim step
// - gain restores nominal 1 ppm analog step
// - final analog trim read-only, bits 7:6 zero
// - final digital trim read-only sign-magnitude
`timescale 1ns/100ps
`include "rtc_temp_comp_consts.vh"

module rtc_temp_compensation_ctrl #(
  parameter [20:0] CONV_CYCLES = `CONV_CYCLES,
  parameter [35:0] LONG_CYCLES = `PERIOD_LONG_CYCLES,
  parameter [35:0] SHORT_CYCLES = `PERIOD_SHORT_CYCLES,
  parameter [9:0] TURNOVER = `TURNOVER_CODE
) (
  input wire sys_clk,
  input wire reset,
  // device register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // values held by neighbouring registers
  input wire [7:0] alpha_hot,
  input wire [5:0] initial_analog_trim,
  input wire [4:0] initial_digital_trim,
  // analog side, asynchronous to sys_clk
  input wire [9:0] temp_code,
  input wire battery_mode,
  input wire vbat_low,
  // controls toward the sensor and the oscillator trim
  output wire sensor_enable,
  output reg [9:0] temp_result,
  output reg [5:0] analog_trim,
  output reg [4:0] digital_trim,
  output wire sense_busy
);

  ////////////////////////////////////////////////////////////////////
  // states of the sense cycle
  localparam [1:0] ST_IDLE = 2'b00; // waiting for enable or period
  localparam [1:0] ST_CONV1 = 2'b01; // first conversion running
  localparam [1:0] ST_CONV2 = 2'b10; // second conversion running
  localparam [1:0] ST_CALC = 2'b11; // average and trim update

  // half of the total sequence for each of the two conversions
  localparam [20:0] HALF_CYCLES = {1'b0, CONV_CYCLES[20:1]};

  ////////////////////////////////////////////////////////////////////
  // register state
  reg [7:0] alpha_cold_q; // cold-side coefficient byte
  reg [7:0] ctrl_q; // sense enables, rate and step gain
  reg [5:0] final_at_q; // last computed analog trim
  reg [4:0] final_dt_q; // last computed digital trim

  // sequencer state
  reg [1:0] state_q; // current sense cycle state
  reg [1:0] state_d; // next sense cycle state
  reg [20:0] conv_cnt_q; // cycles into the current conversion
  reg [9:0] sample1_q; // first conversion result

  // synchronisers for the analog-side inputs
  reg [9:0] temp_m_q; // first stage, read only by the second
  reg [9:0] temp_s_q; // settled temperature code
  reg batt_m_q; // first stage of battery mode
  reg batt_s_q; // settled battery mode
  reg low_m_q; // first stage of low battery flag
  reg low_s_q; // settled low battery flag

  // decoded controls
  wire temp_sense_enable; // temperature sense enable
  wire battery_comp_enable; // battery compensation enable
  wire battery_comp_rate; // battery compensation rate
  wire [4:0] gain; // analog trim step gain
  wire comp_allowed; // sensing may run in the present supply mode
  wire start_wr; // write that sets the sense enable
  wire period_tick; // periodic repeat request
  wire conv_done; // current conversion has run its time
  wire [10:0] sum; // sum of the two samples
  wire [5:0] calc_at; // freshly computed analog trim
  wire [4:0] calc_dt; // freshly computed digital trim

  assign temp_sense_enable = ctrl_q[`TSE_BIT];
  assign battery_comp_enable = ctrl_q[`BATTERY_COMP_ENABLE_BIT];
  assign battery_comp_rate = ctrl_q[`BATTERY_COMP_RATE_BIT];
  assign gain = ctrl_q[`GAIN_MSB:`GAIN_LSB];

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; the temperature bus only settles between
  // conversions, so a per-bit crossing is safe where it is sampled
  always @(posedge sys_clk) begin
    if (reset) begin
      temp_m_q <= 10'h000;
      temp_s_q <= 10'h000;
      batt_m_q <= 1'b0;
      batt_s_q <= 1'b0;
      low_m_q <= 1'b0;
      low_s_q <= 1'b0;
    end else begin
      temp_m_q <= temp_code;
      temp_s_q <= temp_m_q;
      batt_m_q <= battery_mode;
      batt_s_q <= batt_m_q;
      low_m_q <= vbat_low;
      low_s_q <= low_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // compensation permission for the present supply
  // main supply: sense enable alone; battery: also the battery enable
  // and a healthy battery
  assign comp_allowed = temp_sense_enable && (!batt_s_q || (battery_comp_enable && !low_s_q));

  // a write with the enable set restarts a cycle once sensing is already allowed, which is what lets
  // the second of the two gain writes take effect at once
  assign start_wr = reg_wr && (reg_addr == `SENSE_CTRL_ADDR)
                 && reg_wdata[`TSE_BIT];

  ////////////////////////////////////////////////////////////////////
  // register writes; final trim addresses take no write
  always @(posedge sys_clk) begin
    if (reset) begin
      alpha_cold_q <= `ALPHA_RESET;
      ctrl_q <= `CTRL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `ALPHA_COLD_ADDR: begin
          alpha_cold_q <= reg_wdata;
        end
        `SENSE_CTRL_ADDR: begin
          ctrl_q <= reg_wdata;
        end
        default: begin
          // final trims and unmapped addresses ignore writes
          alpha_cold_q <= alpha_cold_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register reads, captured on the read strobe
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= `READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `ALPHA_COLD_ADDR: begin
          reg_rdata <= alpha_cold_q;
        end
        `SENSE_CTRL_ADDR: begin
          reg_rdata <= ctrl_q;
        end
        `FINAL_AT_ADDR: begin
          reg_rdata <= {2'b00, final_at_q};
        end
        `FINAL_DT_ADDR: begin
          reg_rdata <= {3'b000, final_dt_q};
        end
        default: begin
          reg_rdata <= `READ_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // repeat timer: battery mode uses the rate bit, main supply the short
  // period; it only runs between cycles
  comp_period_timer #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
  ) u_period (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(comp_allowed && (state_q == ST_IDLE)),
    .use_short(!batt_s_q || battery_comp_rate),
    .tick(period_tick)
  );

  assign conv_done = (conv_cnt_q >= HALF_CYCLES - 21'h000001);

  ////////////////////////////////////////////////////////////////////
  // sense cycle next state; losing permission aborts without update
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (comp_allowed && (start_wr || period_tick)) begin
          state_d = ST_CONV1;
        end
      end
      ST_CONV1: begin
        if (!comp_allowed) begin
          state_d = ST_IDLE;
        end else if (conv_done) begin
          state_d = ST_CONV2;
        end
      end
      ST_CONV2: begin
        if (!comp_allowed) begin
          state_d = ST_IDLE;
        end else if (conv_done) begin
          state_d = ST_CALC;
        end
      end
      ST_CALC: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // a restart write while compensation is allowed begins a fresh pair of conversions
    if (start_wr && comp_allowed && state_q != ST_IDLE) begin
      state_d = ST_CONV1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register, conversion timer and first sample
  always @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= 21'h000000;
      sample1_q <= 10'h000;
    end else begin
      state_q <= state_d;
      if (state_d != state_q || state_d == ST_IDLE || start_wr) begin
        conv_cnt_q <= 21'h000000;
      end else begin
        conv_cnt_q <= conv_cnt_q + 21'h000001;
      end
      if (state_q == ST_CONV1 && conv_done) begin
        sample1_q <= temp_s_q;
      end
    end
  end

  // the sensor and converter run only inside a cycle
  assign sensor_enable = (state_q == ST_CONV1) || (state_q == ST_CONV2);
  assign sense_busy = (state_q != ST_IDLE);

  // average of the two conversions
  assign sum = {1'b0, sample1_q} + {1'b0, temp_s_q};

  ////////////////////////////////////////////////////////////////////
  // trim arithmetic on the averaged temperature
  trim_calc #(
    .TURNOVER(TURNOVER)
  ) u_calc (
    .temp_avg(temp_result),
    .alpha_cold(alpha_cold_q),
    .alpha_hot(alpha_hot),
    .gain(gain),
    .init_at(initial_analog_trim),
    .init_dt(initial_digital_trim),
    .final_at(calc_at),
    .final_dt(calc_dt)
  );

  ////////////////////////////////////////////////////////////////////
  // temperature result then both final trims one cycle later, the two
  // trims always changing on the same edge
  always @(posedge sys_clk) begin
    if (reset) begin
      temp_result <= 10'h000;
      final_at_q <= `FINAL_AT_RESET;
      final_dt_q <= `FINAL_DT_RESET;
    end else begin
      if (state_q == ST_CONV2 && state_d == ST_CALC) begin
        temp_result <= sum[10:1];
      end
      if (state_q == ST_CALC) begin
        final_at_q <= calc_at;
        final_dt_q <= calc_dt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trims applied to the oscillator: initial values while sensing is
  // off, otherwise the last computed pair, which stays put while
  // battery compensation is suppressed
  always @(posedge sys_clk) begin
    if (reset) begin
      analog_trim <= `FINAL_AT_RESET;
      digital_trim <= `FINAL_DT_RESET;
    end else if (!temp_sense_enable) begin
      analog_trim <= initial_analog_trim;
      digital_trim <= initial_digital_trim;
    end else begin
      analog_trim <= final_at_q;
      digital_trim <= final_dt_q;
    end
  end

endmodule

// *** test/rtc_temp_compensation_ctrl_checker.sv ***
// port-level assertions for the temperature compensation control
`timescale 1ns/100ps
`include "rtc_temp_comp_consts.vh"

module rtc_temp_compensation_ctrl_checker #(
  parameter [20:0] CONV_CYCLES = 21'h000028
) (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [5:0] initial_analog_trim,
  input wire [4:0] initial_digital_trim,
  input wire sensor_enable,
  input wire [9:0] temp_result,
  input wire [5:0] analog_trim,
  input wire [4:0] digital_trim,
  input wire sense_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  int unsigned run_q; // consecutive cycles with the sensor powered
  logic [7:0] alpha_q; // shadow of the cold coefficient
  logic [7:0] ctrl_q; // shadow of the control byte
  wire mapped = (reg_addr >= `ALPHA_COLD_ADDR) && (reg_addr <= `FINAL_DT_ADDR);

  // shadows track writes so read data is predicted from the port alone
  always @(posedge sys_clk) begin
    if (reset) begin
      alpha_q <= 8'h00;
      ctrl_q <= 8'h00;
      run_q <= 0;
    end else begin
      if (reg_wr && reg_addr == `ALPHA_COLD_ADDR) begin
        alpha_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SENSE_CTRL_ADDR) begin
        ctrl_q <= reg_wdata;
      end
      // a restart write begins a fresh pair of conversions, so the count restarts too
      run_q <= (sensor_enable && !(reg_wr && reg_addr == `SENSE_CTRL_ADDR
                && reg_wdata[`TSE_BIT])) ? run_q + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_sense_in_busy: assert property (sensor_enable |-> sense_busy)
    else $error("sensor powered while sequencer idle");
  // an abort drops busy together with the sensor, so only full runs are timed
  a_sense_length: assert property ($fell(sensor_enable) && sense_busy |-> run_q == CONV_CYCLES)
    else $error("conversion sequence length wrong");
  a_idle_initial: assert property (!$past(ctrl_q[`TSE_BIT]) && !$past(reset) |->
    analog_trim == $past(initial_analog_trim) && digital_trim == $past(initial_digital_trim))
    else $error("trims do not follow initial values while sensing off");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fat_upper: assert property (reg_rd && reg_addr == `FINAL_AT_ADDR |=> reg_rdata[7:6] == 2'h0)
    else $error("final analog trim upper bits set");
  a_fdt_format: assert property (reg_rd && reg_addr == `FINAL_DT_ADDR |=>
    reg_rdata[7:5] == 3'h0 && reg_rdata[3:0] <= 4'hA)
    else $error("final digital trim out of format");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_coeff_read: assert property (reg_rd && !reg_wr && reg_addr == `ALPHA_COLD_ADDR |=>
    reg_rdata == $past(alpha_q))
    else $error("cold coefficient readback wrong");
  a_ctrl_read: assert property (reg_rd && !reg_wr && reg_addr == `SENSE_CTRL_ADDR |=>
    reg_rdata == $past(ctrl_q))
    else $error("control byte readback wrong");
  a_result_in_cycle: assert property ($changed(temp_result) |-> $past(sense_busy))
    else $error("temperature result moved outside a sense cycle");

  c_full_run: cover property ($fell(sensor_enable) && sense_busy);
  c_fdt_read: cover property (reg_rd && reg_addr == `FINAL_DT_ADDR);
  c_unmapped: cover property (reg_rd && !mapped);
endmodule

bind rtc_temp_compensation_ctrl rtc_temp_compensation_ctrl_checker #(
  .CONV_CYCLES(CONV_CYCLES)
) rtc_temp_compensation_ctrl_checker_inst (
  .sys_clk(sys_clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .initial_analog_trim(initial_analog_trim),
  .initial_digital_trim(initial_digital_trim),
  .sensor_enable(sensor_enable),
  .temp_result(temp_result),
  .analog_trim(analog_trim),
  .digital_trim(digital_trim),
  .sense_busy(sense_busy)
);

// *** test/test_rtc_temp_compensation_ctrl.sv ***
// self-checking bench for the temperature compensation control
`timescale 1ns/100ps
`include "rtc_temp_comp_consts.vh"

module test_rtc_temp_compensation_ctrl;
  localparam [20:0] CONV = 21'h000028; // shortened 22 ms sequence
  localparam [35:0] LONG = 36'h0000000C8; // shortened ten-minute period
  localparam [35:0] SHORT = 36'h000000032; // shortened one-minute period
  logic sys_clk, reset, reg_wr, reg_rd, battery_mode, vbat_low;
  logic [7:0] reg_addr, reg_wdata, alpha_hot;
  logic [5:0] initial_analog_trim;
  logic [4:0] initial_digital_trim;
  logic [9:0] temp_code;
  logic [7:0] addr_tab [5]; // reset-value sweep, last entry unmapped
  wire [7:0] reg_rdata;
  wire [9:0] temp_result;
  wire [5:0] analog_trim;
  wire [4:0] digital_trim;
  wire sensor_enable, sense_busy;
  int err_total, n_checks, n;

  rtc_temp_compensation_ctrl #(
    .CONV_CYCLES(CONV),
    .LONG_CYCLES(LONG),
    .SHORT_CYCLES(SHORT)
  ) rtc_temp_compensation_ctrl_inst (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alpha_hot(alpha_hot),
    .initial_analog_trim(initial_analog_trim), .initial_digital_trim(initial_digital_trim),
    .temp_code(temp_code), .battery_mode(battery_mode), .vbat_low(vbat_low),
    .sensor_enable(sensor_enable), .temp_result(temp_result), .analog_trim(analog_trim),
    .digital_trim(digital_trim), .sense_busy(sense_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // inputs always move one step after the edge so sampling never races
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // two cycles per access so a strobe is never raised in the step it dropped
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick();
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    chk({2'h0, reg_rdata}, {2'h0, exp});
  endtask

  // cycles until sensor_enable goes from low to high; limit means never
  task automatic wait_rise(input int limit, output int cnt);
    logic prev;
    prev = sensor_enable;
    cnt = 0;
    while (cnt < limit && !(sensor_enable === 1'b1 && prev === 1'b0)) begin
      prev = sensor_enable;
      tick();
      cnt++;
    end
  endtask

  // length of the powered phase; the converter input moves part way through
  task automatic high_len(input logic [9:0] late, output int cnt);
    cnt = 0;
    do begin
      tick();
      cnt++;
      if (cnt == 25) begin
        temp_code = late;
      end
    end while (sensor_enable === 1'b1 && cnt < 1000);
  endtask

  task automatic settle(input int limit);
    int k;
    k = 0;
    while (sense_busy === 1'b1 && k < limit) begin
      tick();
      k++;
    end
  endtask

  // the first rise may come from a write, so only the last interval is kept
  task automatic period(input int limit, output int cnt);
    repeat (3) wait_rise(limit, cnt);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // about two thousand cycles are expected; this leaves wide margin
  initial begin
    #(20 * 8000);
    err_total++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, battery_mode, vbat_low} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    alpha_hot = 8'h30;
    initial_analog_trim = 6'h05;
    initial_digital_trim = 5'h12;
    temp_code = 10'h250;
    addr_tab = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h20};
    repeat (10) tick();
    reset = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(addr_tab[i], 8'h00);
    end
    chk({4'h0, analog_trim}, 10'h005);
    initial_analog_trim = 6'h23;
    repeat (2) tick();
    chk({4'h0, analog_trim}, 10'h023);
    chk({5'h00, digital_trim}, 10'h012);
    // coefficient storage and the read-only or unmapped places
    wr(`ALPHA_COLD_ADDR, 8'h46);
    rd(`ALPHA_COLD_ADDR, 8'h46);
    wr(`FINAL_AT_ADDR, 8'hFF);
    wr(`FINAL_DT_ADDR, 8'hFF);
    wr(8'h20, 8'hFF);
    rd(`FINAL_AT_ADDR, 8'h00);
    rd(`FINAL_DT_ADDR, 8'h00);
    rd(8'h20, 8'h00);
    // gain with sensing off, then the same gain twice with sensing on
    wr(`SENSE_CTRL_ADDR, 8'h10);
    rd(`SENSE_CTRL_ADDR, 8'h10);
    wr(`SENSE_CTRL_ADDR, 8'h90);
    wr(`SENSE_CTRL_ADDR, 8'h90);
    n = 0;
    while (sensor_enable !== 1'b1 && n < 3) begin
      tick();
      n++;
    end
    chk(10'(n < 3), 10'h001);
    high_len(10'h24C, n);
    chk(10'(n), 10'(CONV));
    settle(5);
    tick();
    chk(temp_result, 10'h24E);
    chk({4'h0, analog_trim}, 10'h023);
    rd(`FINAL_AT_ADDR, 8'h23);
    rd(`FINAL_DT_ADDR, 8'h12);
    temp_code = 10'h24E;
    // battery mode with compensation disabled stays quiet
    battery_mode = 1'b1;
    repeat (5) tick();
    settle(100);
    wait_rise(400, n);
    chk(10'(n == 400), 10'h001);
    // low battery suppresses even with fast battery compensation enabled
    vbat_low = 1'b1;
    repeat (3) tick();
    wr(`SENSE_CTRL_ADDR, 8'hF0);
    wait_rise(400, n);
    chk(10'(n == 400), 10'h001);
    chk({9'h000, sense_busy}, 10'h000);
    rd(`FINAL_AT_ADDR, 8'h23);
    rd(`FINAL_DT_ADDR, 8'h12);
    // healthy battery: one-minute rate, then ten-minute rate
    vbat_low = 1'b0;
    wait_rise(150, n);
    chk(10'(n < 150), 10'h001);
    high_len(10'h24E, n);
    chk(10'(n), 10'(CONV));
    period(150, n);
    // rise to rise: two conversions, the calc cycle, the idle period and its tick
    chk(10'(n), 10'(CONV + SHORT + 2));
    wr(`SENSE_CTRL_ADDR, 8'hD0);
    period(300, n);
    chk(10'(n), 10'(CONV + LONG + 2));
    // sensing off again returns control to the initial trims
    wr(`SENSE_CTRL_ADDR, 8'h00);
    battery_mode = 1'b0;
    initial_analog_trim = 6'h07;
    settle(100);
    repeat (3) tick();
    chk({4'h0, analog_trim}, 10'h007);
    wait_rise(200, n);
    chk(10'(n == 200), 10'h001);
    complete_run();
  end
endmodule
